// file: tcm_defs.svh
`ifndef TCM_DEFS_SVH
`define TCM_DEFS_SVH

// Register byte offsets
`define TCM_OFF_MODE_LOW 8'h18
`define TCM_OFF_MODE_HIGH 8'h1c
`define TCM_OFF_CHAN_EN 8'h20
`define TCM_OFF_CMP_BASE 8'h34
`define TCM_OFF_LOCK 8'h44
`define TCM_OFF_STATUS 8'h48
`define TCM_CMP_STRIDE 8'h04

// Reset values
`define TCM_MODE_RESET 16'h0000
`define TCM_CHAN_EN_RESET 16'h0000
`define TCM_CMP_RESET 16'h0000
`define TCM_LOCK_RESET 2'h0

// Field positions: 8 mode bits per channel, 4 enable-register bits per channel
`define TCM_CH_BITS 8
`define TCM_EN_STRIDE 4
`define TCM_EN_BIT 0
`define TCM_P_BIT 1
`define TCM_NP_BIT 3

// Channel direction codes
`define TCM_DIR_OUT 2'h0
`define TCM_DIR_OWN 2'h1
`define TCM_DIR_NEIGH 2'h2
`define TCM_DIR_TRIG 2'h3

// Compare mode codes
`define TCM_OCM_FROZEN 3'h0
`define TCM_OCM_SET 3'h1
`define TCM_OCM_CLR 3'h2
`define TCM_OCM_TOGGLE 3'h3
`define TCM_OCM_LOW 3'h4
`define TCM_OCM_HIGH 3'h5
`define TCM_OCM_PWM1 3'h6
`define TCM_OCM_PWM2 3'h7

// Protection level that freezes compare mode and preload enable while the channel is set as output
`define TCM_LOCK_FULL 2'h3

// Trigger sample stages ahead of the reference flop: 2 + 1 = 3 cycles
`define TCM_FAST_STAGES 2

// Bus responses
`define TCM_RESP_OKAY 2'h0
`define TCM_RESP_SLVERR 2'h2

`endif

// file: tcm_pkg.sv
package tcm_pkg;
  // One channel's mode byte seen as output stage
  typedef struct packed {
    logic clr_en;
    logic [2:0] mode;
    logic pe;
    logic fe;
    logic [1:0] dir;
  } tcm_oc_cfg_t;

  // The same byte seen as input stage
  typedef struct packed {
    logic [3:0] filt;
    logic [1:0] psc;
    logic [1:0] dir;
  } tcm_ic_cfg_t;

  // Counter state supplied by the time base
  typedef struct packed {
    logic [15:0] value;
    logic down;
  } tcm_cnt_t;
endpackage

// file: tcm_channel_mode.sv
`include "tcm_defs.svh"
module tcm_channel_mode #(
  parameter int ADDR_W = 8,
  parameter int NCH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire tcm_pkg::tcm_cnt_t counter_value,
  input wire logic update_event,
  input wire logic external_trigger_filtered,
  input wire logic trigger_edge,
  input wire logic [NCH-1:0] timer_input,
  input wire logic internal_trigger_input,
  input wire logic trigger_source_internal,
  output logic [NCH-1:0] output_reference,
  output logic [NCH-1:0] oc_out,
  output logic [NCH-1:0] ocn_out,
  output logic [NCH-1:0] capture_event
);

  logic [15:0] channel_mode_low;
  logic [15:0] channel_mode_high;
  logic [15:0] channel_enable_reg;
  logic [1:0] lock_level;
  logic [15:0] cmp_shadow [NCH];
  logic [15:0] compare_value_reg [NCH];
  logic [NCH-1:0] ic_level;
  logic [4:0] dts_div;
  logic aw_hold;
  logic w_hold;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] mode_all;
  logic wr_go;

  assign mode_all = {channel_mode_high, channel_mode_low};
  assign wr_go = aw_hold && w_hold && !s_axi_bvalid;

  // Byte-lane merge for the 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Protect a channel's mode byte against writes the hardware refuses
  function automatic logic [7:0] guard(input logic [7:0] old, input logic [7:0] nw,
                                       input logic en, input logic lock3);
    guard = nw;
    if (en) begin
      guard[1:0] = old[1:0];
    end
    if (lock3 && old[1:0] == `TCM_DIR_OUT) begin
      guard[6:3] = old[6:3];
    end
  endfunction

  // Mode register write with both channels of the byte pair guarded
  function automatic logic [15:0] mode_wr(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] en, input logic lock3);
    mode_wr = {guard(old[15:8], nw[15:8], en[1], lock3), guard(old[7:0], nw[7:0], en[0], lock3)};
  endfunction

  function automatic logic [1:0] en_pair(input logic [15:0] r, input int base);
    en_pair = {r[(base + 1) * `TCM_EN_STRIDE + `TCM_EN_BIT], r[base * `TCM_EN_STRIDE + `TCM_EN_BIT]};
  endfunction

  // Filter length N for a code
  function automatic logic [3:0] filt_len(input logic [3:0] c);
    case (c)
      4'h1: filt_len = 4'h2;
      4'h2: filt_len = 4'h4;
      4'h4, 4'h6, 4'h8, 4'hb, 4'he: filt_len = 4'h6;
      4'ha, 4'hd: filt_len = 4'h5;
      default: filt_len = 4'h8;
    endcase
  endfunction

  // Sampling divider mask relative to the dead-time clock
  function automatic logic [4:0] filt_mask(input logic [3:0] c);
    if (c < 4'h4) begin
      filt_mask = 5'h00;
    end else if (c < 4'h6) begin
      filt_mask = 5'h01;
    end else if (c < 4'h8) begin
      filt_mask = 5'h03;
    end else if (c < 4'ha) begin
      filt_mask = 5'h07;
    end else if (c < 4'hd) begin
      filt_mask = 5'h0f;
    end else begin
      filt_mask = 5'h1f;
    end
  endfunction

  // Free-running divider for the slow filter sampling rates
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dts_div <= 5'h00;
    end else begin
      dts_div <= dts_div + 5'h01;
    end
  end

  // Write address and data are held independently, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TCM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_hold) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_hold) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_go) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr[1:0] != 2'h0 || aw_addr == `TCM_OFF_STATUS || aw_addr > `TCM_OFF_STATUS ||
            (aw_addr > `TCM_OFF_CHAN_EN && aw_addr < `TCM_OFF_CMP_BASE) || aw_addr < `TCM_OFF_MODE_LOW) begin
          s_axi_bresp <= `TCM_RESP_SLVERR;
        end else begin
          s_axi_bresp <= `TCM_RESP_OKAY;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration registers; stored once, read as either stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_mode_low <= `TCM_MODE_RESET;
      channel_mode_high <= `TCM_MODE_RESET;
      channel_enable_reg <= `TCM_CHAN_EN_RESET;
      lock_level <= `TCM_LOCK_RESET;
    end else if (wr_go) begin
      if (aw_addr == `TCM_OFF_MODE_LOW) begin
        channel_mode_low <= mode_wr(channel_mode_low, merge16(channel_mode_low, w_data, w_strb),
                                    en_pair(channel_enable_reg, 0), lock_level == `TCM_LOCK_FULL);
      end else if (aw_addr == `TCM_OFF_MODE_HIGH) begin
        channel_mode_high <= mode_wr(channel_mode_high, merge16(channel_mode_high, w_data, w_strb),
                                     en_pair(channel_enable_reg, 2), lock_level == `TCM_LOCK_FULL);
      end else if (aw_addr == `TCM_OFF_CHAN_EN) begin
        channel_enable_reg <= merge16(channel_enable_reg, w_data, w_strb);
      end else if (aw_addr == `TCM_OFF_LOCK && w_strb[0]) begin
        lock_level <= w_data[1:0];
      end
    end
  end

  // Compare values: shadow always written, active follows at once or on update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NCH; i++) begin
        cmp_shadow[i] <= `TCM_CMP_RESET;
        compare_value_reg[i] <= `TCM_CMP_RESET;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (update_event && mode_all[i * `TCM_CH_BITS + 3]) begin
          compare_value_reg[i] <= cmp_shadow[i];
        end
        if (wr_go && aw_addr == `TCM_OFF_CMP_BASE + ADDR_W'(i * 4)) begin
          cmp_shadow[i] <= merge16(cmp_shadow[i], w_data, w_strb);
          if (!mode_all[i * `TCM_CH_BITS + 3]) begin
            compare_value_reg[i] <= merge16(cmp_shadow[i], w_data, w_strb);
          end
        end
      end
    end
  end

  // Read channel; one read in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `TCM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `TCM_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      if (s_axi_araddr == `TCM_OFF_MODE_LOW) begin
        s_axi_rdata[15:0] <= channel_mode_low;
      end else if (s_axi_araddr == `TCM_OFF_MODE_HIGH) begin
        s_axi_rdata[15:0] <= channel_mode_high;
      end else if (s_axi_araddr == `TCM_OFF_CHAN_EN) begin
        s_axi_rdata[15:0] <= channel_enable_reg;
      end else if (s_axi_araddr == `TCM_OFF_CMP_BASE) begin
        s_axi_rdata[15:0] <= cmp_shadow[0];
      end else if (s_axi_araddr == `TCM_OFF_CMP_BASE + `TCM_CMP_STRIDE) begin
        s_axi_rdata[15:0] <= cmp_shadow[1];
      end else if (s_axi_araddr == `TCM_OFF_CMP_BASE + 2 * `TCM_CMP_STRIDE) begin
        s_axi_rdata[15:0] <= cmp_shadow[2];
      end else if (s_axi_araddr == `TCM_OFF_CMP_BASE + 3 * `TCM_CMP_STRIDE) begin
        s_axi_rdata[15:0] <= cmp_shadow[3];
      end else if (s_axi_araddr == `TCM_OFF_LOCK) begin
        s_axi_rdata[1:0] <= lock_level;
      end else if (s_axi_araddr == `TCM_OFF_STATUS) begin
        s_axi_rdata[7:0] <= {ic_level, output_reference};
      end else begin
        s_axi_rresp <= `TCM_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    tcm_pkg::tcm_oc_cfg_t oc;
    tcm_pkg::tcm_ic_cfg_t ic;
    logic en;
    logic pol;
    logic npol;
    logic match;
    logic match_d;
    logic pwm_lvl;
    logic prev_lvl;
    logic [2:0] prev_mode;
    logic [`TCM_FAST_STAGES-1:0] trig_sh;
    logic next_ref;
    logic src;
    logic raw;
    logic [3:0] flt_cnt;
    logic flt_d;
    logic [2:0] psc_cnt;
    logic [2:0] psc_mask;
    logic edge_ok;

    assign oc = tcm_pkg::tcm_oc_cfg_t'(mode_all[i * `TCM_CH_BITS +: `TCM_CH_BITS]);
    assign ic = tcm_pkg::tcm_ic_cfg_t'(mode_all[i * `TCM_CH_BITS +: `TCM_CH_BITS]);
    assign en = channel_enable_reg[i * `TCM_EN_STRIDE + `TCM_EN_BIT];
    assign pol = channel_enable_reg[i * `TCM_EN_STRIDE + `TCM_P_BIT];
    assign npol = channel_enable_reg[i * `TCM_EN_STRIDE + `TCM_NP_BIT];
    assign match = counter_value.value == compare_value_reg[i];
    assign psc_mask = {ic.psc == 2'h3, ic.psc[1], ic.psc != 2'h0};
    assign edge_ok = (ic_level[i] != flt_d) && (ic_level[i] ^ pol);

    // PWM level from the live comparison, counting direction aware
    always_comb begin
      if (!counter_value.down) begin
        pwm_lvl = counter_value.value < compare_value_reg[i];
      end else begin
        pwm_lvl = !(counter_value.value > compare_value_reg[i]);
      end
      if (oc.mode == `TCM_OCM_PWM2) begin
        pwm_lvl = !pwm_lvl;
      end
    end

    // Next reference level; clear input has top priority
    always_comb begin
      next_ref = output_reference[i];
      case (oc.mode)
        `TCM_OCM_FROZEN: next_ref = output_reference[i];
        `TCM_OCM_SET: if (match && !match_d) next_ref = 1'b1;
        `TCM_OCM_CLR: if (match && !match_d) next_ref = 1'b0;
        `TCM_OCM_TOGGLE: if (match && !match_d) next_ref = !output_reference[i];
        `TCM_OCM_LOW: next_ref = 1'b0;
        `TCM_OCM_HIGH: next_ref = 1'b1;
        default: begin
          // Fast path only exists in the PWM modes; it is ignored elsewhere
          if (oc.fe && trig_sh[`TCM_FAST_STAGES-1]) begin
            next_ref = oc.mode == `TCM_OCM_PWM2;
          end else if (pwm_lvl != prev_lvl || prev_mode == `TCM_OCM_FROZEN) begin
            next_ref = pwm_lvl;
          end
        end
      endcase
      if (oc.clr_en && external_trigger_filtered) begin
        next_ref = 1'b0;
      end
      if (oc.dir != `TCM_DIR_OUT) begin
        next_ref = 1'b0;
      end
    end

    // Output stage; pins carry their own polarity, reference stays active high
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        output_reference[i] <= 1'b0;
        oc_out[i] <= 1'b0;
        ocn_out[i] <= 1'b0;
        match_d <= 1'b0;
        prev_lvl <= 1'b0;
        prev_mode <= `TCM_OCM_FROZEN;
        trig_sh <= '0;
      end else begin
        output_reference[i] <= next_ref;
        oc_out[i] <= next_ref ^ pol;
        ocn_out[i] <= next_ref ^ npol;
        match_d <= match;
        prev_lvl <= pwm_lvl;
        prev_mode <= oc.mode;
        trig_sh <= {trig_sh[`TCM_FAST_STAGES-2:0], trigger_edge};
      end
    end

    // Source select; internal mapping dead unless internal trigger chosen
    always_comb begin
      case (ic.dir)
        `TCM_DIR_OWN: src = timer_input[i];
        `TCM_DIR_NEIGH: src = timer_input[i ^ 1];
        `TCM_DIR_TRIG: src = internal_trigger_input && trigger_source_internal;
        default: src = 1'b0;
      endcase
    end

    // Digital filter: N agreeing samples at the coded rate
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        raw <= 1'b0;
        flt_cnt <= 4'h0;
        ic_level[i] <= 1'b0;
        flt_d <= 1'b0;
      end else begin
        raw <= src;
        flt_d <= ic_level[i];
        if (ic.dir == `TCM_DIR_OUT || ic.filt == 4'h0) begin
          ic_level[i] <= raw;
          flt_cnt <= 4'h0;
        end else if ((dts_div & filt_mask(ic.filt)) == 5'h00) begin
          if (raw == ic_level[i]) begin
            flt_cnt <= 4'h0;
          end else if (flt_cnt + 4'h1 >= filt_len(ic.filt)) begin
            ic_level[i] <= raw;
            flt_cnt <= 4'h0;
          end else begin
            flt_cnt <= flt_cnt + 4'h1;
          end
        end
      end
    end

    // Event prescaler; a disabled channel holds it at zero
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        psc_cnt <= 3'h0;
        capture_event[i] <= 1'b0;
      end else if (!en) begin
        psc_cnt <= 3'h0;
        capture_event[i] <= 1'b0;
      end else if (ic.dir != `TCM_DIR_OUT && edge_ok) begin
        if ((psc_cnt & psc_mask) == psc_mask) begin
          psc_cnt <= 3'h0;
          capture_event[i] <= 1'b1;
        end else begin
          psc_cnt <= psc_cnt + 3'h1;
          capture_event[i] <= 1'b0;
        end
      end else begin
        capture_event[i] <= 1'b0;
      end
    end
  end

endmodule

// file: tcm_pins.sv
module tcm_pins (
  input wire logic aclk,
  input wire logic [3:0] pin_set,
  output logic [3:0] timer_input
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins move just after the edge, like a source already synchronised to the timer clock
  always_ff @(posedge aclk) begin
    timer_input <= pin_set;
  end
endmodule

// file: tcm_chk.sv
module tcm_chk #(
  parameter int NCH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NCH-1:0] output_reference,
  input wire logic [NCH-1:0] oc_out,
  input wire logic [NCH-1:0] ocn_out,
  input wire logic [NCH-1:0] capture_event
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Bus answers stand until taken and come at the stated distance
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_b_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  // Registers are at most 16 bits wide, so the upper read half is always empty
  property p_upper;
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  // Pin levels keep a fixed relation to the reference unless a write just landed
  property p_pol_oc;
    !s_axi_bvalid && !$past(s_axi_bvalid) |-> $stable(oc_out ^ output_reference);
  endproperty
  a_pol_oc: assert property (p_pol_oc) else $error("main pin drifts from reference");
  property p_pol_ocn;
    !s_axi_bvalid && !$past(s_axi_bvalid) |-> $stable(ocn_out ^ output_reference);
  endproperty
  a_pol_ocn: assert property (p_pol_ocn) else $error("complement pin drifts");
  property p_cap_once;
    |capture_event |=> (capture_event & $past(capture_event)) == '0;
  endproperty
  a_cap_once: assert property (p_cap_once) else $error("capture pulse too long");
  property p_rst;
    $past(aresetn) == 1'b0 |-> output_reference == '0 && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_cap: cover property (capture_event[0]);
  c_ref: cover property ($rose(output_reference[0]));
endmodule
bind tcm_channel_mode tcm_chk #(.NCH(NCH)) u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .output_reference(output_reference), .oc_out(oc_out), .ocn_out(ocn_out), .capture_event(capture_event));

// file: tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  tcm_pkg::tcm_cnt_t cnt = '0;
  logic upd = 1'h0, etf = 1'h0, trg = 1'h0, tsi = 1'h0;
  logic [4:0] drv = 5'h00;
  logic [3:0] tin, oref, oc, ocn, cap;
  int n_fail = 0, n_tests = 0, cap_n = 0;
  // Clock and a running tally of channel 0 captures
  always #10 aclk = ~aclk;
  always @(posedge aclk) if (cap[0]) cap_n++;
  tcm_channel_mode dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .counter_value(cnt),
    .update_event(upd), .external_trigger_filtered(etf), .trigger_edge(trg), .timer_input(tin),
    .internal_trigger_input(drv[4]), .trigger_source_internal(tsi), .output_reference(oref),
    .oc_out(oc), .ocn_out(ocn), .capture_event(cap));
  tcm_pins pins (.aclk(aclk), .pin_set(drv[3:0]), .timer_input(tin));
  task automatic stop_test;
    $display("Counts: %0d compared, %0d bad", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic ck(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic st(input int k);
    repeat (k) @(posedge aclk);
  endtask
  // Bus tasks hold every request until its ready edge; a hang ends at the watchdog
  // Each call first lets an edge pass, so a ready is never lowered and raised in one step
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    ck(34'(bresp), 34'(er));
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    ck({rresp, rdata}, {er, 16'h0000, exp});
  endtask
  // Reference is looked at just after the edge has landed, then drivers realign
  task automatic rf(input logic e);
    st(4);
    #1;
    ck(34'(oref[0]), 34'(e));
    @(posedge aclk);
  endtask
  task automatic hit(input logic e);
    cnt <= {16'h0100, 1'h0};
    rf(e);
    cnt <= {16'h0050, 1'h0};
    st(2);
  endtask
  task automatic trig;
    trg <= 1'h1;
    @(posedge aclk);
    trg <= 1'h0;
  endtask
  task automatic cfg(input logic [15:0] m);
    wr(8'h20, 16'h0000);
    wr(8'h18, m);
    wr(8'h20, 16'h0001);
    cap_n = 0;
  endtask
  task automatic pl(input logic [4:0] m, input int w, input int k);
    repeat (k) begin
      drv <= m;
      st(w);
      drv <= 5'h00;
      st(12);
    end
  endtask
  task automatic t_regs;
    rchk(8'h18, 16'h0000);
    rchk(8'h1c, 16'h0000);
    wr(8'h1c, 16'h6c6c);
    rchk(8'h1c, 16'h6c6c);
    wr(8'h1c, 16'h0000);
    rchk(8'h00, 16'h0000, 2'h2);
    wr(8'h48, 16'h0001, 2'h2);
  endtask
  task automatic t_out;
    logic [15:0] v;
    wr(8'h18, 16'h0040);
    rf(0);
    wr(8'h18, 16'h0050);
    rf(1);
    ck(34'({oc[0], ocn[0]}), 34'h3);
    wr(8'h20, 16'h000a);
    rf(1);
    ck(34'({oc[0], ocn[0]}), 34'h0);
    wr(8'h20, 16'h0000);
    wr(8'h34, 16'h0100);
    wr(8'h18, 16'h0040);
    cnt <= {16'h0050, 1'h0};
    wr(8'h18, 16'h0010);
    hit(1);
    wr(8'h18, 16'h0020);
    hit(0);
    wr(8'h18, 16'h0030);
    hit(1);
    hit(0);
    hit(1);
    wr(8'h18, 16'h0000);
    hit(1);
    for (int m = 6; m < 8; m++) begin
      wr(8'h18, 16'h0008);
      wr(8'h18, 16'(m * 16 + 8));
      for (int k = 0; k < 6; k++) begin
        v = 16'h00ff + 16'(k % 3);
        cnt <= {v, k > 2};
        rf(((k > 2) ? (v > 16'h0100) : (v >= 16'h0100)) ^ (m == 6));
      end
    end
  endtask
  task automatic t_misc;
    wr(8'h18, 16'h00d0);
    etf <= 1'h1;
    rf(0);
    wr(8'h18, 16'h0050);
    rf(1);
    etf <= 1'h0;
    wr(8'h18, 16'h0008);
    cnt <= {16'h0050, 1'h0};
    wr(8'h18, 16'h007c);
    rf(0);
    trig;
    st(1);
    #1;
    ck(34'(oref[0]), 34'h0);
    st(1);
    #1;
    ck(34'(oref[0]), 34'h1);
    @(posedge aclk);
    wr(8'h18, 16'h003c);
    trig;
    rf(1);
    wr(8'h18, 16'h0040);
    wr(8'h18, 16'h0018);
    wr(8'h34, 16'h0050);
    rf(0);
    upd <= 1'h1;
    @(posedge aclk);
    upd <= 1'h0;
    rf(1);
    wr(8'h18, 16'h0040);
    wr(8'h18, 16'h0010);
    wr(8'h34, 16'h0060);
    cnt <= {16'h0060, 1'h0};
    rf(1);
  endtask
  task automatic t_in;
    wr(8'h20, 16'h0001);
    wr(8'h18, 16'h0001);
    rchk(8'h18, 16'h0000);
    cfg(16'h0005);
    pl(5'h01, 2, 4);
    ck(34'(cap_n), 34'h2);
    cfg(16'h000d);
    pl(5'h01, 2, 3);
    wr(8'h20, 16'h0000);
    wr(8'h20, 16'h0001);
    pl(5'h01, 2, 7);
    ck(34'(cap_n), 34'h0);
    pl(5'h01, 2, 1);
    ck(34'(cap_n), 34'h1);
    // No prescaling here, so one neighbour edge gives exactly one capture
    cfg(16'h0002);
    pl(5'h02, 2, 1);
    pl(5'h01, 2, 2);
    ck(34'(cap_n), 34'h1);
    cfg(16'h0003);
    tsi <= 1'h1;
    pl(5'h10, 2, 1);
    tsi <= 1'h0;
    pl(5'h10, 2, 1);
    ck(34'(cap_n), 34'h1);
    cfg(16'h0031);
    pl(5'h01, 6, 1);
    ck(34'(cap_n), 34'h0);
    pl(5'h01, 10, 1);
    ck(34'(cap_n), 34'h1);
    wr(8'h20, 16'h0000);
    wr(8'h18, 16'h003c);
    wr(8'h44, 16'h0003);
    wr(8'h18, 16'h0040);
    rchk(8'h18, 16'h0038);
    wr(8'h18, 16'h0041);
    wr(8'h18, 16'h0041);
    rchk(8'h18, 16'h0041);
  endtask
  // Main sequence after ten reset cycles
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_regs;
    t_out;
    t_misc;
    t_in;
    stop_test;
  end
  // Watchdog well beyond the fewer than one thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    stop_test;
  end
endmodule
